/* File: rtl/sshe_params.svh */
// Constants for the subtract, shift and halt execution block
`ifndef SSHE_PARAMS_SVH
`define SSHE_PARAMS_SVH
// Opcodes, subtract
`define SSHE_OP_SUB_RR 8'h22
`define SSHE_OP_SUB_RIR 8'h23
`define SSHE_OP_SUB_GG 8'h24
`define SSHE_OP_SUB_GIR 8'h25
`define SSHE_OP_SUB_GIM 8'h26
// Opcodes, subtract with borrow
`define SSHE_OP_SBC_RR 8'h32
`define SSHE_OP_SBC_RIR 8'h33
`define SSHE_OP_SBC_GG 8'h34
`define SSHE_OP_SBC_GIR 8'h35
`define SSHE_OP_SBC_GIM 8'h36
// Opcodes, shift, carry preset, halt
`define SSHE_OP_SRA_G 8'hd0
`define SSHE_OP_SRA_IR 8'hd1
`define SSHE_OP_SCF 8'hdf
`define SSHE_OP_HALT 8'h7f
// Unlock value that allows the halt to stop the clocks
`define SSHE_UNLOCK_KEY 8'ha5
// Instruction lengths in bytes
`define SSHE_LEN_1 2'h1
`define SSHE_LEN_2 2'h2
`define SSHE_LEN_3 2'h3
// Execution times in CPU cycles
`define SSHE_CYC_4 3'h4
`define SSHE_CYC_6 3'h6
`define SSHE_CYC_ONE 3'h1
`define SSHE_CYC_ZERO 3'h0
// Bit positions
`define SSHE_MSB 7
`define SSHE_MSB_M1 6
`endif

/* File: rtl/sshe_pkg.sv */
// Types for the subtract, shift and halt execution block
package sshe_pkg;
   typedef enum logic [2:0] {
      SSHE_IDLE = 3'h1,
      SSHE_EXEC = 3'h2,
      SSHE_STOP = 3'h4
   } sshe_state_t;
   typedef enum logic [5:0] {
      SSHE_K_NONE = 6'h01,
      SSHE_K_SUB = 6'h02,
      SSHE_K_SBC = 6'h04,
      SSHE_K_SRA = 6'h08,
      SSHE_K_SCF = 6'h10,
      SSHE_K_HALT = 6'h20
   } sshe_kind_t;
endpackage : sshe_pkg

/* File: rtl/sshe_exec.sv */
// Execution unit for subtract, subtract with borrow, shift, carry preset and halt
`timescale 1ns/1ps
`default_nettype none
`include "sshe_params.svh"
module sshe_exec #(
   parameter int DATA_W = 8
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic start_in,
   input wire logic [7:0] opcode_in,
   input wire logic [DATA_W-1:0] dst_in,
   input wire logic [DATA_W-1:0] src_in,
   input wire logic [7:0] halt_unlock_reg_in,
   input wire logic ext_irq_in,
   output logic [DATA_W-1:0] result_out,
   output logic result_we_out,
   output logic done_out,
   output logic illegal_out,
   output logic [1:0] bytes_out,
   output logic [2:0] cycles_out,
   output logic carry_out,
   output logic zero_out,
   output logic sign_out,
   output logic ovf_out,
   output logic stopped_out,
   output logic cpu_clk_en_out,
   output logic sys_clk_en_out,
   output logic pc_to_reset_out
);
   import sshe_pkg::*;

   // The flag and sign logic is written for a byte-wide datapath only
   if (DATA_W != 8) begin : g_bad_width
      $error("sshe_exec supports DATA_W of 8 only");
   end

   sshe_state_t state_q, state_d;
   sshe_kind_t kind_q, kind_d, dec_kind;
   logic [1:0] dec_len;
   logic [2:0] dec_cyc;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] dst_q, dst_d, src_q, src_d;
   logic cin_q, cin_d;
   logic [7:0] res_q, res_d;
   logic we_q, we_d, done_q, done_d, ill_q, ill_d, pcr_q, pcr_d;
   logic [1:0] len_q, len_d;
   logic [2:0] cyc_q, cyc_d;
   logic c_q, c_d, z_q, z_d, s_q, s_d, v_q, v_d;
   logic stop_q, stop_d, cen_q, cen_d;
   logic irq_s1_q, irq_s2_q;
   logic [8:0] diff;
   logic [7:0] sra_res;

   // Interrupt pin is asynchronous; two stages before any use
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_s1_q <= 1'b0;
         irq_s2_q <= 1'b0;
      end else begin
         irq_s1_q <= ext_irq_in;
         irq_s2_q <= irq_s1_q;
      end
   end

   // Opcode decode: kind, length and execution time
   always_comb begin
      dec_kind = SSHE_K_NONE;
      dec_len = `SSHE_LEN_1;
      dec_cyc = `SSHE_CYC_4;
      case (opcode_in)
         `SSHE_OP_SUB_RR, `SSHE_OP_SBC_RR: begin
            dec_len = `SSHE_LEN_2;
            dec_cyc = `SSHE_CYC_4;
         end
         `SSHE_OP_SUB_RIR, `SSHE_OP_SBC_RIR: begin
            dec_len = `SSHE_LEN_2;
            dec_cyc = `SSHE_CYC_6;
         end
         `SSHE_OP_SUB_GG, `SSHE_OP_SUB_GIR, `SSHE_OP_SUB_GIM,
         `SSHE_OP_SBC_GG, `SSHE_OP_SBC_GIR, `SSHE_OP_SBC_GIM: begin
            dec_len = `SSHE_LEN_3;
            dec_cyc = `SSHE_CYC_6;
         end
         `SSHE_OP_SRA_G, `SSHE_OP_SRA_IR: begin
            dec_kind = SSHE_K_SRA;
            dec_len = `SSHE_LEN_2;
         end
         `SSHE_OP_SCF: dec_kind = SSHE_K_SCF;
         `SSHE_OP_HALT: dec_kind = SSHE_K_HALT;
         default: dec_kind = SSHE_K_NONE;
      endcase
      // Subtract families share the length table above
      if (opcode_in inside {`SSHE_OP_SUB_RR, `SSHE_OP_SUB_RIR, `SSHE_OP_SUB_GG,
            `SSHE_OP_SUB_GIR, `SSHE_OP_SUB_GIM}) begin
         dec_kind = SSHE_K_SUB;
      end
      if (opcode_in inside {`SSHE_OP_SBC_RR, `SSHE_OP_SBC_RIR, `SSHE_OP_SBC_GG,
            `SSHE_OP_SBC_GIR, `SSHE_OP_SBC_GIM}) begin
         dec_kind = SSHE_K_SBC;
      end
   end

   // Datapath on the latched operands; borrow drops out as bit 8
   always_comb begin
      diff = {1'b0, dst_q} - {1'b0, src_q} - {8'h00, cin_q};
      sra_res = {dst_q[`SSHE_MSB], dst_q[`SSHE_MSB:1]};
   end

   // Sequencer and architectural state next values
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      cnt_d = cnt_q;
      dst_d = dst_q;
      src_d = src_q;
      cin_d = cin_q;
      res_d = res_q;
      len_d = len_q;
      cyc_d = cyc_q;
      c_d = c_q;
      z_d = z_q;
      s_d = s_q;
      v_d = v_q;
      stop_d = stop_q;
      cen_d = cen_q;
      we_d = 1'b0;
      done_d = 1'b0;
      ill_d = 1'b0;
      pcr_d = 1'b0;
      case (state_q)
         SSHE_IDLE: begin
            if (start_in) begin
               kind_d = dec_kind;
               dst_d = dst_in;
               src_d = src_in;
               // Plain subtract takes no borrow in
               cin_d = (dec_kind == SSHE_K_SBC) ? c_q : 1'b0;
               len_d = dec_len;
               cyc_d = dec_cyc;
               cnt_d = dec_cyc - `SSHE_CYC_ONE;
               if (dec_kind == SSHE_K_NONE) begin
                  // Unknown opcode answered at once; result and flags hold, length and cycles still load
                  ill_d = 1'b1;
                  done_d = 1'b1;
               end else begin
                  state_d = SSHE_EXEC;
               end
            end
         end
         SSHE_EXEC: begin
            if (cnt_q != `SSHE_CYC_ZERO) begin
               cnt_d = cnt_q - `SSHE_CYC_ONE;
            end else begin
               done_d = 1'b1;
               state_d = SSHE_IDLE;
               case (kind_q)
                  SSHE_K_SUB, SSHE_K_SBC: begin
                     res_d = diff[7:0];
                     we_d = 1'b1;
                     c_d = diff[8];
                     z_d = (diff[7:0] == 8'h00);
                     s_d = diff[`SSHE_MSB];
                     v_d = (dst_q[`SSHE_MSB] ^ src_q[`SSHE_MSB]) &
                           (diff[`SSHE_MSB] == src_q[`SSHE_MSB]);
                  end
                  SSHE_K_SRA: begin
                     res_d = sra_res;
                     we_d = 1'b1;
                     c_d = dst_q[0];
                     z_d = (sra_res == 8'h00);
                     s_d = sra_res[`SSHE_MSB];
                     v_d = 1'b0;
                  end
                  SSHE_K_SCF: c_d = 1'b1;
                  SSHE_K_HALT: begin
                     if (halt_unlock_reg_in == `SSHE_UNLOCK_KEY) begin
                        // Both clocks gate off; flags untouched
                        state_d = SSHE_STOP;
                        stop_d = 1'b1;
                        cen_d = 1'b0;
                     end else begin
                        pcr_d = 1'b1;
                     end
                  end
                  default: ill_d = 1'b1;
               endcase
            end
         end
         SSHE_STOP: begin
            // Nothing but the interrupt pin moves state; reset is the async path
            // All operand, result and flag registers simply hold here
            if (irq_s2_q) begin
               state_d = SSHE_IDLE;
               stop_d = 1'b0;
               cen_d = 1'b1;
            end
         end
         default: state_d = SSHE_IDLE;
      endcase
   end

   // Register everything; reset is also the other way out of stop
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= SSHE_IDLE;
         kind_q <= SSHE_K_NONE;
         cnt_q <= `SSHE_CYC_ZERO;
         dst_q <= 8'h00;
         src_q <= 8'h00;
         cin_q <= 1'b0;
         res_q <= 8'h00;
         len_q <= 2'h0;
         cyc_q <= 3'h0;
         c_q <= 1'b0;
         z_q <= 1'b0;
         s_q <= 1'b0;
         v_q <= 1'b0;
         stop_q <= 1'b0;
         cen_q <= 1'b1;
         we_q <= 1'b0;
         done_q <= 1'b0;
         ill_q <= 1'b0;
         pcr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         cnt_q <= cnt_d;
         dst_q <= dst_d;
         src_q <= src_d;
         cin_q <= cin_d;
         res_q <= res_d;
         len_q <= len_d;
         cyc_q <= cyc_d;
         c_q <= c_d;
         z_q <= z_d;
         s_q <= s_d;
         v_q <= v_d;
         stop_q <= stop_d;
         cen_q <= cen_d;
         we_q <= we_d;
         done_q <= done_d;
         ill_q <= ill_d;
         pcr_q <= pcr_d;
      end
   end

   // Outputs straight from flops
   assign result_out = res_q;
   assign result_we_out = we_q;
   assign done_out = done_q;
   assign illegal_out = ill_q;
   assign bytes_out = len_q;
   assign cycles_out = cyc_q;
   assign carry_out = c_q;
   assign zero_out = z_q;
   assign sign_out = s_q;
   assign ovf_out = v_q;
   assign stopped_out = stop_q;
   assign cpu_clk_en_out = cen_q;
   assign sys_clk_en_out = cen_q;
   assign pc_to_reset_out = pcr_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   // Result, flag, timing and halt checks; results checked on commit against the latched operands
   sbc_result_a: assert property (we_q && kind_q == SSHE_K_SBC |->
         res_q == 8'(dst_q - src_q - {7'h00, cin_q}))
      else $error("borrow subtract result wrong");
   sbc_carry_a: assert property (we_q && kind_q == SSHE_K_SBC |->
         c_q == ({1'b0, src_q} + {8'h00, cin_q} > {1'b0, dst_q}))
      else $error("borrow subtract carry wrong");
   sub_ovf_a: assert property (we_q && kind_q inside {SSHE_K_SUB, SSHE_K_SBC} |->
         v_q == ((dst_q[7] != src_q[7]) && res_q[7] == src_q[7]))
      else $error("subtract overflow wrong");
   sub_zs_a: assert property (we_q && kind_q inside {SSHE_K_SUB, SSHE_K_SBC} |->
         z_q == (res_q == 8'h00) && s_q == res_q[7])
      else $error("subtract zero or sign wrong");
   sbc_time_a: assert property (state_q == SSHE_IDLE && start_in &&
         opcode_in == 8'h32 |-> ##5 done_q && len_q == 2'h2)
      else $error("borrow subtract timing wrong");
   scf_flags_a: assert property (done_q && kind_q == SSHE_K_SCF |->
         c_q && z_q == $past(z_q) && s_q == $past(s_q) && v_q == $past(v_q))
      else $error("carry preset wrong");
   sra_shift_a: assert property (we_q && kind_q == SSHE_K_SRA |->
         res_q == {dst_q[7], dst_q[7:1]} && c_q == dst_q[0])
      else $error("shift result wrong");
   sra_flags_a: assert property (we_q && kind_q == SSHE_K_SRA |->
         !v_q && z_q == (res_q == 8'h00) && s_q == res_q[7])
      else $error("shift flags wrong");
   sra_time_a: assert property (state_q == SSHE_IDLE && start_in &&
         opcode_in == 8'hd1 |-> ##1 !done_q [*4] ##1 done_q)
      else $error("shift timing wrong");
   halt_stop_a: assert property ($rose(stop_q) |-> !cen_q && c_q == $past(c_q) &&
         $past(halt_unlock_reg_in == 8'ha5))
      else $error("halt entry wrong");
   stop_keep_a: assert property (stop_q && !irq_s2_q |=> stop_q && $stable(res_q) &&
         $stable({c_q, z_q, s_q, v_q}))
      else $error("stop state lost contents");
   wake_cause_a: assert property ($fell(stop_q) |-> $past(irq_s2_q))
      else $error("stop left without interrupt");
   halt_lock_a: assert property (done_q && kind_q == SSHE_K_HALT && !stop_q |->
         pc_to_reset_out && $past(halt_unlock_reg_in != 8'ha5))
      else $error("locked halt did not reset pc");
   sub_carry_a: assert property (we_q && kind_q == SSHE_K_SUB |->
         c_q == (src_q > dst_q) && res_q == 8'(dst_q - src_q))
      else $error("plain subtract wrong");
   sub_time_a: assert property (state_q == SSHE_IDLE && start_in &&
         opcode_in == 8'h26 |-> ##7 done_q && len_q == 2'h3)
      else $error("plain subtract timing wrong");
   sub_ovf2_a: assert property (we_q && kind_q == SSHE_K_SUB && dst_q[7] == src_q[7]
         |-> !v_q)
      else $error("plain subtract overflow wrong");

   // Main scenarios
   cov_sbc_borrow: cover property (we_q && kind_q == SSHE_K_SBC && cin_q && c_q);
   cov_sra_neg: cover property (we_q && kind_q == SSHE_K_SRA && res_q[7]);
   cov_stop_wake: cover property ($rose(stop_q) ##[1:50] $fell(stop_q));
   cov_halt_lock: cover property (pc_to_reset_out);
endmodule : sshe_exec
`default_nettype wire

/* File: tb/sshe_wake_src.sv */
// Model of the outside reset and interrupt sources that wake the core
`timescale 1ns/1ps
`default_nettype none
module sshe_wake_src #(
   parameter int SETTLE = 8,
   parameter int IRQ_HOLD = 6
) (
   input wire logic clk_in,
   input wire logic rst_req_in,
   input wire logic irq_req_in,
   output var logic arst_n_out,
   output var logic irq_out
);
   int rst_cnt = 2;
   int irq_cnt = 0;
   // Power-up reset low; pins start quiet; one driver per pin
   logic rst_lvl = 1'b0;
   logic irq_lvl = 1'b0;
   assign arst_n_out = rst_lvl;
   assign irq_out = irq_lvl;
   // Requests taken on the rising edge so the bench drive never races
   always @(posedge clk_in) begin
      if (rst_req_in) begin
         rst_cnt <= SETTLE;
      end else if (rst_cnt > 0) begin
         rst_cnt <= rst_cnt - 1;
      end
      if (irq_req_in) begin
         irq_cnt <= IRQ_HOLD;
      end else if (irq_cnt > 0) begin
         irq_cnt <= irq_cnt - 1;
      end
   end
   // Reset stays low through oscillator settling; released line pulled low
   always @(negedge clk_in) begin
      rst_lvl <= (rst_cnt == 0);
      irq_lvl <= (irq_cnt != 0);
   end
endmodule : sshe_wake_src
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the subtract, shift and halt execution block
`timescale 1ns/1ps
`default_nettype none
`include "sshe_params.svh"
module testbench;
   import sshe_pkg::*;
   logic clk_in = 1'b0;
   logic start = 1'b0;
   logic rst_req = 1'b0;
   logic irq_req = 1'b0;
   logic [7:0] opcode = 8'h00, dst = 8'h00, src = 8'h00, key = 8'h00;
   wire logic arst_n, irq, we, done, illegal, stopped, cpu_en, sys_en, pc_rst;
   wire logic c_f, z_f, s_f, v_f;
   wire logic [7:0] result;
   wire logic [1:0] bytes;
   wire logic [2:0] cycles;
   wire logic [3:0] flags;
   int err_count = 0;
   int cmp_count = 0;
   int n_seen;
   logic we_seen, pcr_seen, ill_seen;
   logic [3:0] ef = 4'h0;
   assign flags = {c_f, z_f, s_f, v_f};
   // 25 MHz clock
   always #20 clk_in = ~clk_in;
   sshe_wake_src i_src (.clk_in(clk_in), .rst_req_in(rst_req), .irq_req_in(irq_req),
      .arst_n_out(arst_n), .irq_out(irq));
   sshe_exec i_dut (.clk_in(clk_in), .arst_n_in(arst_n), .start_in(start),
      .opcode_in(opcode), .dst_in(dst), .src_in(src), .halt_unlock_reg_in(key),
      .ext_irq_in(irq), .result_out(result), .result_we_out(we), .done_out(done),
      .illegal_out(illegal), .bytes_out(bytes), .cycles_out(cycles), .carry_out(c_f),
      .zero_out(z_f), .sign_out(s_f), .ovf_out(v_f), .stopped_out(stopped),
      .cpu_clk_en_out(cpu_en), .sys_clk_en_out(sys_en), .pc_to_reset_out(pc_rst));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // One instruction; counts edges from take to done, pulses sampled then
   task automatic exec(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
      opcode = op;
      dst = d;
      src = s;
      start = 1'b1;
      @(negedge clk_in);
      start = 1'b0;
      n_seen = -1;
      for (int k = 0; k <= 20 && n_seen < 0; k++) begin
         if (done === 1'b1) begin
            n_seen = k;
            we_seen = we;
            pcr_seen = pc_rst;
            ill_seen = illegal;
         end else begin
            @(negedge clk_in);
         end
      end
   endtask : exec
   // Arithmetic with the expected result and flags worked out here
   task automatic alu(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
      input logic [1:0] len, input logic [2:0] cyc);
      logic [8:0] w;
      logic [7:0] r;
      w = {1'b0, d} - {1'b0, s} - {8'h00, (op[7:4] == 4'h3) & ef[3]};
      r = (op[7:4] == 4'hd) ? {d[7], d[7:1]} : w[7:0];
      if (op[7:4] == 4'hd) begin
         ef = {d[0], r == 8'h00, r[7], 1'b0};
      end else begin
         ef = {w[8], r == 8'h00, r[7], (d[7] != s[7]) && (r[7] == s[7])};
      end
      exec(op, d, s);
      chk("time", {5'h0, cyc}, n_seen[7:0]);
      chk("result", r, result);
      chk("write", 8'h01, {7'h0, we_seen});
      chk("flags", {4'h0, ef}, {4'h0, flags});
      chk("length", {6'h0, len}, {6'h0, bytes});
      chk("cycles", {5'h0, cyc}, {5'h0, cycles});
   endtask : alu
   task automatic t_sub();
      alu(`SSHE_OP_SUB_RR, 8'h12, 8'h03, 2'h2, 3'h4);
      alu(`SSHE_OP_SUB_RIR, 8'h21, 8'h90, 2'h2, 3'h6);
      alu(`SSHE_OP_SUB_GG, 8'h21, 8'h65, 2'h3, 3'h6);
      alu(`SSHE_OP_SUB_GIR, 8'h05, 8'h05, 2'h3, 3'h6);
      alu(`SSHE_OP_SUB_GIM, 8'h7f, 8'hff, 2'h3, 3'h6);
   endtask : t_sub
   // Borrow chains across bytes, carry preset first
   task automatic t_sbc();
      exec(`SSHE_OP_SCF, 8'h00, 8'h00);
      ef[3] = 1'b1;
      alu(`SSHE_OP_SBC_RR, 8'h10, 8'h03, 2'h2, 3'h4);
      alu(`SSHE_OP_SBC_RIR, 8'h00, 8'h01, 2'h2, 3'h6);
      alu(`SSHE_OP_SBC_GG, 8'h00, 8'h00, 2'h3, 3'h6);
      alu(`SSHE_OP_SBC_GIR, 8'h20, 8'h8a, 2'h3, 3'h6);
      alu(`SSHE_OP_SBC_GIM, 8'h80, 8'h7f, 2'h3, 3'h6);
   endtask : t_sbc
   task automatic t_scf();
      exec(`SSHE_OP_SCF, 8'h00, 8'h00);
      ef[3] = 1'b1;
      chk("time", 8'h04, n_seen[7:0]);
      chk("flags", {4'h0, ef}, {4'h0, flags});
      chk("write", 8'h00, {7'h0, we_seen});
      chk("length", 8'h01, {6'h0, bytes});
   endtask : t_scf
   // Unknown opcode answered at the taking edge, nothing written
   task automatic t_illegal();
      exec(8'h00, 8'h55, 8'h11);
      chk("time", 8'h00, n_seen[7:0]);
      chk("illegal", 8'h01, {7'h0, ill_seen});
      chk("write", 8'h00, {7'h0, we_seen});
      chk("flags", {4'h0, ef}, {4'h0, flags});
   endtask : t_illegal
   task automatic t_sra();
      alu(`SSHE_OP_SRA_G, 8'h9a, 8'h00, 2'h2, 3'h4);
      alu(`SSHE_OP_SRA_IR, 8'hbc, 8'h00, 2'h2, 3'h4);
      alu(`SSHE_OP_SRA_G, 8'h01, 8'h00, 2'h2, 3'h4);
      alu(`SSHE_OP_SRA_IR, 8'h81, 8'h00, 2'h2, 3'h4);
   endtask : t_sra
   task automatic t_halt_nokey();
      key = 8'h00;
      exec(`SSHE_OP_HALT, 8'h00, 8'h00);
      chk("time", 8'h04, n_seen[7:0]);
      chk("to_reset", 8'h01, {7'h0, pcr_seen});
      chk("no_stop", 8'h03, {5'h0, stopped, cpu_en, sys_en});
      chk("flags", {4'h0, ef}, {4'h0, flags});
   endtask : t_halt_nokey
   // Stop, refuse work, wake on interrupt with state kept
   task automatic t_halt_irq();
      logic [7:0] held;
      held = result;
      key = `SSHE_UNLOCK_KEY;
      exec(`SSHE_OP_HALT, 8'h00, 8'h00);
      chk("stop", 8'h04, {5'h0, stopped, cpu_en, sys_en});
      chk("flags", {4'h0, ef}, {4'h0, flags});
      key = 8'h00;
      opcode = `SSHE_OP_SUB_RR;
      start = 1'b1;
      @(negedge clk_in);
      start = 1'b0;
      n_seen = 0;
      repeat (8) begin
         @(negedge clk_in);
         if (done === 1'b1) n_seen++;
      end
      chk("refused", 8'h00, n_seen[7:0]);
      chk("stop", 8'h04, {5'h0, stopped, cpu_en, sys_en});
      irq_req = 1'b1;
      @(negedge clk_in);
      irq_req = 1'b0;
      for (int k = 0; k < 12 && stopped !== 1'b0; k++) @(negedge clk_in);
      chk("wake", 8'h03, {5'h0, stopped, cpu_en, sys_en});
      chk("result", held, result);
      chk("flags", {4'h0, ef}, {4'h0, flags});
      for (int k = 0; k < 12 && irq !== 1'b0; k++) @(negedge clk_in);
      alu(`SSHE_OP_SUB_RR, 8'h40, 8'h01, 2'h2, 3'h4);
   endtask : t_halt_irq
   task automatic t_halt_reset();
      key = `SSHE_UNLOCK_KEY;
      exec(`SSHE_OP_HALT, 8'h00, 8'h00);
      chk("stop", 8'h04, {5'h0, stopped, cpu_en, sys_en});
      rst_req = 1'b1;
      @(negedge clk_in);
      rst_req = 1'b0;
      for (int k = 0; k < 20 && arst_n !== 1'b0; k++) @(negedge clk_in);
      for (int k = 0; k < 40 && arst_n !== 1'b1; k++) @(negedge clk_in);
      @(negedge clk_in);
      ef = 4'h0;
      chk("reset", 8'h03, {5'h0, stopped, cpu_en, sys_en});
      chk("flags", 8'h00, {4'h0, flags});
      alu(`SSHE_OP_SBC_GIM, 8'h00, 8'h01, 2'h3, 3'h6);
   endtask : t_halt_reset
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // Main sequence after the power-up reset lets go
   initial begin
      @(posedge arst_n);
      @(negedge clk_in);
      t_sub();
      t_sbc();
      t_scf();
      t_illegal();
      t_sra();
      t_halt_nokey();
      t_halt_irq();
      t_halt_reset();
      wrap_up();
   end
   // Watchdog; tests need under two hundred cycles, allow 2000
   initial begin
      #(40 * 2000);
      err_count++;
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
